/* File: inc/rtcd_pkg.sv */
package rtcd_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register byte offsets
  localparam logic [11:0] YEAR_VALUE_OFFSET = 12'h000;
  localparam logic [11:0] MONTH_AND_DAY_VALUE_OFFSET = 12'h004;
  localparam logic [11:0] DATE_CTRL_OFFSET = 12'h008;

  // Digit widths
  localparam int DIGIT_W = 4;
  localparam int DAY_TENS_W = 2;

  // Year register fields
  localparam int YEAR_TENS_LSB = 4;
  localparam int YEAR_ONES_LSB = 0;
  localparam int YEAR_IMPL_MSB = 7;

  // Month/day register fields
  localparam int MONTH_TENS_BIT = 12;
  localparam int MONTH_ONES_LSB = 8;
  localparam int DAY_TENS_LSB = 4;
  localparam int DAY_ONES_LSB = 0;
  localparam int MONTH_AND_DAY_VALUE_IMPL_MSB = 12;
  localparam int MONTH_AND_DAY_VALUE_GAP_MSB = 7;
  localparam int MONTH_AND_DAY_VALUE_GAP_LSB = 6;

  // Implemented-bit masks
  localparam logic [15:0] YEAR_VALUE_MASK = 16'h00ff;
  localparam logic [15:0] MONTH_AND_DAY_MASK = 16'h1f3f;

  // Control register fields and reset values
  localparam int CTRL_W = 2;
  localparam int CTRL_WREN_BIT = 0;
  localparam int CTRL_DROP_BIT = 1;
  localparam logic CTRL_WREN_RESET = 1'b0;
  localparam logic CTRL_DROP_RESET = 1'b0;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_YEAR = 2'b01,
    SEL_MONTH_AND_DAY_VALUE = 2'b10,
    SEL_CTRL = 2'b11
  } rtcd_sel_t;

  function automatic rtcd_sel_t rtcd_decode(input logic [11:0] addr);
    rtcd_sel_t sel;
    sel = SEL_NONE;
    if (addr == YEAR_VALUE_OFFSET) begin
      sel = SEL_YEAR;
    end else if (addr == MONTH_AND_DAY_VALUE_OFFSET) begin
      sel = SEL_MONTH_AND_DAY_VALUE;
    end else if (addr == DATE_CTRL_OFFSET) begin
      sel = SEL_CTRL;
    end
    return sel;
  endfunction : rtcd_decode

endpackage : rtcd_pkg

/* File: rtl/rtcd_ctrl_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module rtcd_ctrl_reg
  import rtcd_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic ctrl_write, // Accepted write to control
  input wire logic [1:0] ctrl_wdata, // Control write data
  input wire logic date_write_refused, // Date write discarded
  output logic write_enable, // Calendar write enable
  output logic write_dropped // Sticky discarded-write flag
);

  typedef struct packed {
    logic wren;
    logic dropped;
  } rtcd_ctrl_state_t;

  rtcd_ctrl_state_t st_reg;
  rtcd_ctrl_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (ctrl_write) begin
      st_next.wren = ctrl_wdata[CTRL_WREN_BIT];
      if (ctrl_wdata[CTRL_DROP_BIT]) begin
        st_next.dropped = 1'b0;
      end
    end
    // Set beats clear
    if (date_write_refused) begin
      st_next.dropped = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg.wren <= CTRL_WREN_RESET;
      st_reg.dropped <= CTRL_DROP_RESET;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign write_enable = st_reg.wren;
  assign write_dropped = st_reg.dropped;

endmodule : rtcd_ctrl_reg

`default_nettype wire

/* File: rtl/rtcd_date_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module rtcd_date_regs
  import rtcd_pkg::*;
(
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic [3:0] year_tens_digit, // Year tens digit
  output logic [3:0] year_ones_digit, // Year ones digit
  output logic month_tens_digit, // Month tens digit
  output logic [3:0] month_ones_digit, // Month ones digit
  output logic [1:0] day_tens_digit, // Day tens digit
  output logic [3:0] day_ones_digit, // Day ones digit
  output logic calendar_write_enable // Date write enable state
);

  typedef struct packed {
    logic rd_valid;
    logic [31:0] rdata;
    logic year_seen;
    logic month_and_day_value_seen;
  } rtcd_top_state_t;

  rtcd_top_state_t st_reg;
  rtcd_top_state_t st_next;

  rtcd_sel_t sel;
  logic access_done;
  logic wr_ok;
  logic year_wr;
  logic month_and_day_value_wr;
  logic ctrl_wr;
  logic date_refused;
  logic write_dropped;
  logic [15:0] year_q;
  logic [15:0] month_and_day_value_q;
  logic [31:0] read_mux;

  assign sel = rtcd_decode(paddr);

  // Ready once read data has been captured for this transfer
  assign pready = psel & penable & st_reg.rd_valid & clk_en;
  assign pslverr = pready & (sel == SEL_NONE);
  assign access_done = pready;
  assign wr_ok = access_done & pwrite;

  // Date writes gated by the write enable
  assign year_wr = wr_ok & (sel == SEL_YEAR) & calendar_write_enable;
  assign month_and_day_value_wr = wr_ok & (sel == SEL_MONTH_AND_DAY_VALUE) & calendar_write_enable;
  assign ctrl_wr = wr_ok & (sel == SEL_CTRL);
  assign date_refused = wr_ok & ((sel == SEL_YEAR) | (sel == SEL_MONTH_AND_DAY_VALUE))
    & ~calendar_write_enable;

  rtcd_field_reg #(
    .MASK(YEAR_VALUE_MASK)
  ) u_year (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .load(year_wr),
    .load_data(pwdata[15:0]),
    .value(year_q)
  );

  rtcd_field_reg #(
    .MASK(MONTH_AND_DAY_MASK)
  ) u_month_and_day_value (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .load(month_and_day_value_wr),
    .load_data(pwdata[15:0]),
    .value(month_and_day_value_q)
  );

  rtcd_ctrl_reg u_ctrl (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .ctrl_write(ctrl_wr),
    .ctrl_wdata(pwdata[CTRL_W-1:0]),
    .date_write_refused(date_refused),
    .write_enable(calendar_write_enable),
    .write_dropped(write_dropped)
  );

  // Digit fields
  assign year_tens_digit = year_q[YEAR_TENS_LSB +: DIGIT_W];
  assign year_ones_digit = year_q[YEAR_ONES_LSB +: DIGIT_W];
  assign month_tens_digit = month_and_day_value_q[MONTH_TENS_BIT];
  assign month_ones_digit = month_and_day_value_q[MONTH_ONES_LSB +: DIGIT_W];
  assign day_tens_digit = month_and_day_value_q[DAY_TENS_LSB +: DAY_TENS_W];
  assign day_ones_digit = month_and_day_value_q[DAY_ONES_LSB +: DIGIT_W];

  // Read data, upper bits zero
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (sel)
      SEL_YEAR: read_mux = {16'h0000, year_q};
      SEL_MONTH_AND_DAY_VALUE: read_mux = {16'h0000, month_and_day_value_q};
      SEL_CTRL: read_mux = {30'h0000_0000, write_dropped, calendar_write_enable};
      SEL_NONE: read_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // Capture read data once per transfer
    if (psel && !st_reg.rd_valid) begin
      st_next.rd_valid = 1'b1;
      st_next.rdata = read_mux;
    end
    if (access_done) begin
      st_next.rd_valid = 1'b0;
    end
    if (year_wr) begin
      st_next.year_seen = 1'b1;
    end
    if (month_and_day_value_wr) begin
      st_next.month_and_day_value_seen = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_year_write;
    year_wr;
  endsequence

  sequence s_month_and_day_value_write;
    month_and_day_value_wr;
  endsequence

  sequence s_setup_then_access;
    psel && !penable && clk_en && !st_reg.rd_valid ##1 psel && penable && clk_en;
  endsequence

  sequence s_refused;
    date_refused;
  endsequence

  chk_year_tens_load: assert property (
    s_year_write |=> year_tens_digit == $past(pwdata[YEAR_TENS_LSB +: DIGIT_W])
  ) else $error("year tens digit not loaded from bits 7-4");

  chk_year_ones_load: assert property (
    s_year_write |=> year_ones_digit == $past(pwdata[YEAR_ONES_LSB +: DIGIT_W])
  ) else $error("year ones digit not loaded from bits 3-0");

  chk_year_upper_zero: assert property (
    pready && !pwrite && sel == SEL_YEAR |-> prdata[31:YEAR_IMPL_MSB+1] == '0
  ) else $error("year register upper byte read nonzero");

  chk_year_write_gate: assert property (
    st_reg.year_seen && !year_wr |=> $stable(year_q)
  ) else $error("year register changed without enabled write");

  chk_year_gate_cause: assert property (
    year_wr |-> calendar_write_enable && pready && pwrite
  ) else $error("year write taken while write enable clear");

  chk_month_tens_load: assert property (
    s_month_and_day_value_write |=> month_tens_digit == $past(pwdata[MONTH_TENS_BIT])
  ) else $error("month tens digit not loaded from bit 12");

  chk_month_ones_load: assert property (
    s_month_and_day_value_write |=> month_ones_digit == $past(pwdata[MONTH_ONES_LSB +: DIGIT_W])
  ) else $error("month ones digit not loaded from bits 11-8");

  chk_day_tens_load: assert property (
    s_month_and_day_value_write |=> day_tens_digit == $past(pwdata[DAY_TENS_LSB +: DAY_TENS_W])
  ) else $error("day tens digit not loaded from bits 5-4");

  chk_day_ones_load: assert property (
    s_month_and_day_value_write |=> day_ones_digit == $past(pwdata[DAY_ONES_LSB +: DIGIT_W])
  ) else $error("day ones digit not loaded from bits 3-0");

  chk_month_and_day_value_gaps_zero: assert property (
    pready && !pwrite && sel == SEL_MONTH_AND_DAY_VALUE
    |-> prdata[31:MONTH_AND_DAY_VALUE_IMPL_MSB+1] == '0 && prdata[MONTH_AND_DAY_VALUE_GAP_MSB:MONTH_AND_DAY_VALUE_GAP_LSB] == '0
  ) else $error("month/day unimplemented bits read nonzero");

  chk_month_and_day_value_write_gate: assert property (
    st_reg.month_and_day_value_seen && !month_and_day_value_wr |=> $stable(month_and_day_value_q)
  ) else $error("month/day register changed without enabled write");

  chk_refused_no_change: assert property (
    s_refused and (st_reg.year_seen && st_reg.month_and_day_value_seen)
    |=> $stable(year_q) && $stable(month_and_day_value_q) && write_dropped
  ) else $error("discarded date write altered digits or flag");

  chk_access_ready: assert property (
    s_setup_then_access |-> pready ##1 !pready
  ) else $error("access phase not ready in first cycle");

  chk_unmapped_error: assert property (
    pready && sel == SEL_NONE |-> pslverr && prdata == '0
  ) else $error("unmapped access not flagged");

  sequence s_read_done;
    pready && !pwrite;
  endsequence

  sequence s_ctrl_write;
    ctrl_wr;
  endsequence

  chk_ready_one_cycle: assert property (
    pready |=> !pready
  ) else $error("ready held past one access cycle");

  chk_freeze_ctrl: assert property (
    !clk_en |=> $stable(calendar_write_enable) && $stable(write_dropped) && $stable(prdata)
  ) else $error("control or read data changed while clock enable low");

  chk_year_readback: assert property (
    s_read_done and (sel == SEL_YEAR && st_reg.year_seen)
    |-> prdata[REG_W-1:0] == year_q
  ) else $error("year readback differs from stored digits");

  chk_month_and_day_value_readback: assert property (
    s_read_done and (sel == SEL_MONTH_AND_DAY_VALUE && st_reg.month_and_day_value_seen)
    |-> prdata[REG_W-1:0] == month_and_day_value_q
  ) else $error("month/day readback differs from stored digits");

  chk_ctrl_readback: assert property (
    s_read_done and (sel == SEL_CTRL)
    |-> prdata[CTRL_W-1:0] == {write_dropped, calendar_write_enable}
  ) else $error("control readback differs from stored bits");

  chk_wren_load: assert property (
    s_ctrl_write |=> calendar_write_enable == $past(pwdata[CTRL_WREN_BIT])
  ) else $error("write enable not loaded from control write");

  chk_dropped_set: assert property (
    s_refused |=> write_dropped
  ) else $error("discarded date write left flag clear");

  chk_dropped_clear: assert property (
    s_ctrl_write and (pwdata[CTRL_DROP_BIT] && !date_refused) |=> !write_dropped
  ) else $error("flag not cleared by control write");

  chk_dropped_hold: assert property (
    write_dropped && !ctrl_wr |=> write_dropped
  ) else $error("flag cleared without control write");

  chk_refused_no_error: assert property (
    s_refused |-> !pslverr
  ) else $error("discarded date write flagged as bus error");

  chk_unmapped_keeps: assert property (
    pready && pwrite && sel == SEL_NONE
    |=> $stable(calendar_write_enable) && $stable(write_dropped)
  ) else $error("unmapped write altered control bits");

  chk_month_and_day_value_gate_cause: assert property (
    month_and_day_value_wr |-> calendar_write_enable && pready && pwrite
  ) else $error("month/day write taken while write enable clear");

  chk_year_locked: assert property (
    !calendar_write_enable && st_reg.year_seen |=> $stable(year_q)
  ) else $error("year register changed while write enable clear");

  chk_month_and_day_value_locked: assert property (
    !calendar_write_enable && st_reg.month_and_day_value_seen |=> $stable(month_and_day_value_q)
  ) else $error("month/day register changed while write enable clear");

endmodule : rtcd_date_regs

`default_nettype wire

/* File: rtl/rtcd_field_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module rtcd_field_reg
  import rtcd_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic sys_clk, // System clock
  input wire logic clk_en, // Freezes state when low
  input wire logic load, // Accepted write
  input wire logic [15:0] load_data, // Write data
  output logic [15:0] value // Stored bits, unused ones zero
);

  typedef struct packed {
    logic [15:0] value;
  } rtcd_field_state_t;

  rtcd_field_state_t st_reg;
  rtcd_field_state_t st_next;

  // No reset: contents stay undefined until software writes
  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.value = load_data & MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.value & MASK;

endmodule : rtcd_field_reg

`default_nettype wire

/* File: verification/rtcd_date_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module rtcd_date_regs_bench
  import rtcd_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] year_tens_digit;
  logic [3:0] year_ones_digit;
  logic month_tens_digit;
  logic [3:0] month_ones_digit;
  logic [1:0] day_tens_digit;
  logic [3:0] day_ones_digit;
  logic calendar_write_enable;
  int mismatches = 0;
  int n_tests = 0;
  int wait_cnt = 0;
  logic [31:0] seed = 32'h0001_4932;
  logic [31:0] d;
  logic [31:0] e;

  rtcd_date_regs rtcd_date_regs_inst (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .year_tens_digit(year_tens_digit), .year_ones_digit(year_ones_digit),
    .month_tens_digit(month_tens_digit), .month_ones_digit(month_ones_digit),
    .day_tens_digit(day_tens_digit), .day_ones_digit(day_ones_digit),
    .calendar_write_enable(calendar_write_enable)
  );

  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Readback images with unimplemented bits forced to zero
  function automatic logic [31:0] year_exp(input logic [31:0] v);
    return {24'h00_0000, v[7:0]};
  endfunction : year_exp

  function automatic logic [31:0] month_and_day_value_exp(input logic [31:0] v);
    return {19'h0_0000, v[12:8], 2'h0, v[5:0]};
  endfunction : month_and_day_value_exp

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      mismatches++;
      $display("[FAIL] pready expected 1 seen 0");
      finish_test();
    end
    wait_cnt = i;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
    check("write pslverr", {31'h0, err}, {31'h0, exp_err});
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check("read pslverr", {31'h0, err}, {31'h0, exp_err});
    check("read data", rd, exp);
  endtask : rd_chk

  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    check("write enable after reset", {31'h0, calendar_write_enable}, 32'h0);
    rd_chk(DATE_CTRL_OFFSET, 32'h0000_0000, 1'b0);
    $display("Reset test done");

    wr(DATE_CTRL_OFFSET, 32'h0000_0001, 1'b0);
    check("answer latency", wait_cnt, 32'h0);
    for (int k = 0; k < 24; k++) begin
      d = (k == 0) ? 32'hffff_ffff : xs();
      e = (k == 0) ? 32'hffff_ffff : xs();
      wr(YEAR_VALUE_OFFSET, d, 1'b0);
      wr(MONTH_AND_DAY_VALUE_OFFSET, e, 1'b0);
      rd_chk(YEAR_VALUE_OFFSET, year_exp(d), 1'b0);
      rd_chk(MONTH_AND_DAY_VALUE_OFFSET, month_and_day_value_exp(e), 1'b0);
      check("year tens", {28'h0, year_tens_digit}, {28'h0, d[7:4]});
      check("year ones", {28'h0, year_ones_digit}, {28'h0, d[3:0]});
      check("month tens", {31'h0, month_tens_digit}, {31'h0, e[12]});
      check("month ones", {28'h0, month_ones_digit}, {28'h0, e[11:8]});
      check("day tens", {30'h0, day_tens_digit}, {30'h0, e[5:4]});
      check("day ones", {28'h0, day_ones_digit}, {28'h0, e[3:0]});
    end
    check("write enable set", {31'h0, calendar_write_enable}, 32'h1);
    $display("Enabled write test done");

    wr(DATE_CTRL_OFFSET, 32'h0000_0000, 1'b0);
    wr(YEAR_VALUE_OFFSET, ~d, 1'b0);
    wr(MONTH_AND_DAY_VALUE_OFFSET, ~e, 1'b0);
    rd_chk(YEAR_VALUE_OFFSET, year_exp(d), 1'b0);
    rd_chk(MONTH_AND_DAY_VALUE_OFFSET, month_and_day_value_exp(e), 1'b0);
    rd_chk(DATE_CTRL_OFFSET, 32'h0000_0002, 1'b0);
    wr(DATE_CTRL_OFFSET, 32'h0000_0002, 1'b0);
    rd_chk(DATE_CTRL_OFFSET, 32'h0000_0000, 1'b0);
    check("digits kept", {24'h0, year_tens_digit, year_ones_digit}, {24'h0, d[7:0]});
    $display("Refused write test done");

    wr(12'h00c, xs(), 1'b1);
    rd_chk(12'h00c, 32'h0000_0000, 1'b1);
    rd_chk(12'hffc, 32'h0000_0000, 1'b1);
    rd_chk(YEAR_VALUE_OFFSET, year_exp(d), 1'b0);
    $display("Unmapped address test done");

    // Clock enable low across the access phase stretches the answer
    fork
      rd_chk(MONTH_AND_DAY_VALUE_OFFSET, month_and_day_value_exp(e), 1'b0);
      begin
        repeat (2) @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
    join
    check("stalled latency", wait_cnt, 32'h3);
    $display("Clock enable stall test done");
    finish_test();
  end
endmodule : rtcd_date_regs_bench

`default_nettype wire
